// ---- core/phc_pkg.sv ----
package phc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int PHC_ADDR_W = 10;
    localparam logic [9:0] PHC_ADDR_HOLD_CTRL = 10'h01d;
    localparam logic [9:0] PHC_ADDR_ZD_CTRL = 10'h01e;
    localparam logic [9:0] PHC_ADDR_PLL_STATUS = 10'h01f;

    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] PHC_HOLD_CTRL_RST = 8'h80;
    localparam logic [7:0] PHC_ZD_CTRL_RST = 8'h00;
    localparam logic [7:0] PHC_HOLD_CTRL_MASK = 8'hfb;
    localparam logic [7:0] PHC_ZD_CTRL_MASK = 8'h1e;
    localparam logic [7:0] PHC_PLL_STATUS_RST = 8'h00;

    // ------------------------------------------------------------
    // field positions, hold control register
    // ------------------------------------------------------------
    localparam int PHC_B_EEPROM_STATUS = 7;
    localparam int PHC_B_CRYSTAL_AMP = 6;
    localparam int PHC_B_DOUBLER = 5;
    localparam int PHC_B_STATUS_FREEZE = 4;
    localparam int PHC_B_LOCK_CMP = 3;
    localparam int PHC_B_EXT_HOLD = 1;
    localparam int PHC_B_HOLD_EN = 0;

    // ------------------------------------------------------------
    // field positions, zero delay control register
    // ------------------------------------------------------------
    localparam int PHC_B_FB_SEL_HI = 4;
    localparam int PHC_B_FB_SEL_LO = 3;
    localparam int PHC_B_ZD_EXT = 2;
    localparam int PHC_B_ZD_EN = 1;

    // ------------------------------------------------------------
    // status word from the pll section, same clock
    // ------------------------------------------------------------
    typedef struct packed {
        logic vco_cal_done;
        logic holdover_active;
        logic ref2_selected;
        logic vco_above;
        logic ref2_above;
        logic ref1_above;
    } phc_status_t;
endpackage

// ---- core/phc_sync2.sv ----
`timescale 1ns/1ps
module phc_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_r;

    // first stage is read only by the second
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else if (ce_i) begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule

// ---- core/phc_regs.sv ----
// Notes on behaviour
// - Hold-control bit 7 (reset 1) puts the EEPROM status on the status pin, overriding the selected status source.
// - Hold-control bit 6 enables the crystal amplifier at the reference input, off after reset.
// - Hold-control bit 5 enables the reference doubler, off after reset.
// - Hold-control bit 4 set freezes the PLL readback status register; clear lets it follow the PLL.
// - Hold-control bit 3 clear makes the holdover controller see the lock-detect input as true; set uses the comparator.
// - The enabled lock-detect comparator result is offered to the monitor and status pin selection.
// - Hold-control bit 1 hands holdover to the external hold pin and disables internal holdover.
// - Hold-control bit 0 enables internal holdover, off after reset.
// - Zero-delay bits 4:3 select channel divider 0 to 3 for external zero-delay feedback, 0 after reset.
// - Readback status bit 5 reports holdover currently active, not merely enabled.
// - External zero delay is used only when the zero-delay enable and the external mode bits are both set.
`timescale 1ns/1ps
module phc_regs
    import phc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [PHC_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire phc_status_t pll_status_i,
    input wire logic status_sel_i,
    input wire logic eeprom_status_i,
    input wire logic lock_detect_pin_i,
    input wire logic hold_pin_i,
    output logic [7:0] rd_data_o,
    output logic status_pin_o,
    output logic crystal_amplifier_en_o,
    output logic doubler_en_o,
    output logic lock_detect_cmp_o,
    output logic holdover_lock_ok_o,
    output logic internal_holdover_en_o,
    output logic external_holdover_mode_o,
    output logic external_hold_o,
    output logic [1:0] zd_fb_sel_o,
    output logic zd_internal_o,
    output logic zd_external_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] pins_sync;

    phc_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .async_i({lock_detect_pin_i, hold_pin_i}),
        .sync_o(pins_sync)
    );

    wire lock_pin_s = pins_sync[1];
    wire hold_pin_s = pins_sync[0];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] hold_ctrl_r;
    logic [7:0] zd_ctrl_r;
    logic [7:0] pll_status_r;

    wire sel_hold = (addr_i == PHC_ADDR_HOLD_CTRL);
    wire sel_zd = (addr_i == PHC_ADDR_ZD_CTRL);
    wire sel_stat = (addr_i == PHC_ADDR_PLL_STATUS);

    // writes to unused positions are dropped by the masks
    wire [7:0] hold_ctrl_nxt = (wr_en_i && sel_hold) ?
        (wr_data_i & PHC_HOLD_CTRL_MASK) : hold_ctrl_r;
    wire [7:0] zd_ctrl_nxt = (wr_en_i && sel_zd) ?
        (wr_data_i & PHC_ZD_CTRL_MASK) : zd_ctrl_r;

    // bits 7 and 0 have no source and stay zero
    wire [7:0] status_live = {1'b0, pll_status_i, 1'b0};
    wire status_freeze = hold_ctrl_r[PHC_B_STATUS_FREEZE];
    wire [7:0] pll_status_nxt = status_freeze ? pll_status_r : status_live;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_ctrl_r <= PHC_HOLD_CTRL_RST;
        end else if (ce_i) begin
            hold_ctrl_r <= hold_ctrl_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zd_ctrl_r <= PHC_ZD_CTRL_RST;
        end else if (ce_i) begin
            zd_ctrl_r <= zd_ctrl_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pll_status_r <= PHC_PLL_STATUS_RST;
        end else if (ce_i) begin
            pll_status_r <= pll_status_nxt;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // unmapped addresses read zero; data holds between reads
    wire [7:0] rd_mux = sel_hold ? hold_ctrl_r :
                        sel_zd ? zd_ctrl_r :
                        sel_stat ? pll_status_r : 8'h00;
    wire [7:0] rd_data_nxt = rd_en_i ? rd_mux : rd_data_o;

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    wire lock_cmp_en = hold_ctrl_r[PHC_B_LOCK_CMP];
    wire ext_hold_mode = hold_ctrl_r[PHC_B_EXT_HOLD];
    wire status_pin_nxt = hold_ctrl_r[PHC_B_EEPROM_STATUS] ?
        eeprom_status_i : status_sel_i;
    wire lock_cmp_nxt = lock_cmp_en & lock_pin_s;
    // without the comparator a dead pin must not stall holdover
    wire lock_ok_nxt = lock_cmp_en ? lock_pin_s : 1'b1;
    // external mode wins over the internal enable
    wire int_hold_nxt = hold_ctrl_r[PHC_B_HOLD_EN] & ~ext_hold_mode;
    wire ext_hold_nxt = ext_hold_mode & hold_pin_s;
    wire zd_on = zd_ctrl_r[PHC_B_ZD_EN];
    wire zd_ext_nxt = zd_on & zd_ctrl_r[PHC_B_ZD_EXT];
    wire zd_int_nxt = zd_on & ~zd_ctrl_r[PHC_B_ZD_EXT];
    wire crystal_amp_nxt = hold_ctrl_r[PHC_B_CRYSTAL_AMP];
    wire doubler_nxt = hold_ctrl_r[PHC_B_DOUBLER];
    wire [1:0] zd_fb_sel_nxt = zd_ctrl_r[PHC_B_FB_SEL_HI:PHC_B_FB_SEL_LO];

    // ------------------------------------------------------------
    // read data output
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (ce_i) begin
            rd_data_o <= rd_data_nxt;
        end
    end

    // ------------------------------------------------------------
    // status pin and reference input controls
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_pin_o <= 1'b0;
        end else if (ce_i) begin
            status_pin_o <= status_pin_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            crystal_amplifier_en_o <= 1'b0;
        end else if (ce_i) begin
            crystal_amplifier_en_o <= crystal_amp_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            doubler_en_o <= 1'b0;
        end else if (ce_i) begin
            doubler_en_o <= doubler_nxt;
        end
    end

    // ------------------------------------------------------------
    // holdover controls
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_detect_cmp_o <= 1'b0;
        end else if (ce_i) begin
            lock_detect_cmp_o <= lock_cmp_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            holdover_lock_ok_o <= 1'b1;
        end else if (ce_i) begin
            holdover_lock_ok_o <= lock_ok_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            internal_holdover_en_o <= 1'b0;
        end else if (ce_i) begin
            internal_holdover_en_o <= int_hold_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            external_holdover_mode_o <= 1'b0;
        end else if (ce_i) begin
            external_holdover_mode_o <= ext_hold_mode;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            external_hold_o <= 1'b0;
        end else if (ce_i) begin
            external_hold_o <= ext_hold_nxt;
        end
    end

    // ------------------------------------------------------------
    // zero delay controls
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zd_fb_sel_o <= 2'h0;
        end else if (ce_i) begin
            zd_fb_sel_o <= zd_fb_sel_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zd_internal_o <= 1'b0;
        end else if (ce_i) begin
            zd_internal_o <= zd_int_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zd_external_o <= 1'b0;
        end else if (ce_i) begin
            zd_external_o <= zd_ext_nxt;
        end
    end
endmodule

// ---- testbench/phc_regs_sva.sv ----
`timescale 1ns/1ps
module phc_regs_sva
    import phc_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [PHC_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic status_sel_i,
    input wire logic eeprom_status_i,
    input wire logic status_pin_o,
    input wire logic crystal_amplifier_en_o,
    input wire logic doubler_en_o,
    input wire logic internal_holdover_en_o,
    input wire logic external_holdover_mode_o,
    input wire logic [1:0] zd_fb_sel_o,
    input wire logic zd_internal_o,
    input wire logic zd_external_o
);
    // outputs follow a write two enabled edges later
    wire hw = ce_i && wr_en_i && addr_i == PHC_ADDR_HOLD_CTRL;
    wire zw = ce_i && wr_en_i && addr_i == PHC_ADDR_ZD_CTRL;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_crystal; hw ##1 ce_i |=>
        crystal_amplifier_en_o == $past(wr_data_i[6], 2); endproperty
    a_crystal: assert property (p_crystal) else $error("crystal amplifier enable wrong");
    property p_dbl; hw ##1 ce_i |=> doubler_en_o == $past(wr_data_i[5], 2); endproperty
    a_dbl: assert property (p_dbl) else $error("doubler enable wrong");
    property p_ihold; hw ##1 ce_i |=> internal_holdover_en_o ==
        ($past(wr_data_i[0], 2) && !$past(wr_data_i[1], 2)); endproperty
    a_ihold: assert property (p_ihold) else $error("internal holdover wrong");
    property p_xmode; hw ##1 ce_i |=>
        external_holdover_mode_o == $past(wr_data_i[1], 2); endproperty
    a_xmode: assert property (p_xmode) else $error("external mode wrong");
    property p_stpin; hw ##1 ce_i |=> status_pin_o ==
        ($past(wr_data_i[7], 2) ? $past(eeprom_status_i) : $past(status_sel_i)); endproperty
    a_stpin: assert property (p_stpin) else $error("status pin source wrong");
    property p_fbsel; zw ##1 ce_i |=> zd_fb_sel_o == $past(wr_data_i[4:3], 2); endproperty
    a_fbsel: assert property (p_fbsel) else $error("divider select wrong");
    property p_zdext; zw ##1 ce_i |=> zd_external_o ==
        ($past(wr_data_i[1], 2) && $past(wr_data_i[2], 2)); endproperty
    a_zdext: assert property (p_zdext) else $error("external zero delay wrong");
    property p_zdint; zw ##1 ce_i |=> zd_internal_o ==
        ($past(wr_data_i[1], 2) && !$past(wr_data_i[2], 2)); endproperty
    a_zdint: assert property (p_zdint) else $error("internal zero delay wrong");
endmodule
bind phc_regs phc_regs_sva u_sva (.*);

// ---- testbench/phc_regs_bench.sv ----
`timescale 1ns/1ps
module phc_regs_bench;
    import phc_pkg::*;
    logic clock_i = 0, rst_n_i = 0, ce_i = 1, wr_en_i = 0, rd_en_i = 0, hold_pin_i = 0;
    logic status_sel_i = 1, eeprom_status_i = 0, lock_detect_pin_i = 0;
    logic status_pin_o, crystal_amplifier_en_o, doubler_en_o;
    logic lock_detect_cmp_o, holdover_lock_ok_o;
    logic internal_holdover_en_o, external_holdover_mode_o, external_hold_o;
    logic zd_internal_o, zd_external_o;
    logic [1:0] zd_fb_sel_o;
    logic [PHC_ADDR_W-1:0] addr_i = '0;
    logic [7:0] wr_data_i = 8'h00, rd_data_o, v;
    phc_status_t pll_status_i = '0;
    int num_errors = 0, checked = 0;
    wire [7:0] outs = {status_pin_o, crystal_amplifier_en_o, doubler_en_o,
        internal_holdover_en_o, external_holdover_mode_o, zd_fb_sel_o, zd_external_o};
    phc_regs dut (.*);
    always #5 clock_i = ~clock_i;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one access, then one more edge so decoded outputs have landed
    task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_en_i <= w;
        rd_en_i <= !w;
        addr_i <= a;
        wr_data_i <= d;
        @(posedge clock_i);
        wr_en_i <= 0;
        rd_en_i <= 0;
        @(posedge clock_i);
        #1 v = rd_data_o;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_hold;
        acc(0, PHC_ADDR_HOLD_CTRL, 8'h00);
        chk(v, 8'h80);
        chk(outs, 8'h00);
        chk({7'h0, holdover_lock_ok_o}, 8'h01);
        @(posedge clock_i);
        eeprom_status_i <= 1;
        status_sel_i <= 0;
        acc(1, PHC_ADDR_HOLD_CTRL, 8'hff);
        chk(outs, 8'he8);
        acc(0, PHC_ADDR_HOLD_CTRL, 8'h00);
        chk(v, 8'hfb);
        acc(1, PHC_ADDR_HOLD_CTRL, 8'h49);
        chk({outs, lock_detect_cmp_o, holdover_lock_ok_o}, 10'h140);
        // pin is synchronised, so it shows only three edges later
        @(posedge clock_i);
        lock_detect_pin_i <= 1;
        acc(0, PHC_ADDR_ZD_CTRL, 8'h00);
        chk({6'h0, lock_detect_cmp_o, holdover_lock_ok_o}, 8'h03);
        @(posedge clock_i);
        hold_pin_i <= 1;
        acc(1, PHC_ADDR_HOLD_CTRL, 8'h03);
        chk({3'h0, external_hold_o, internal_holdover_en_o, external_holdover_mode_o,
            lock_detect_cmp_o, holdover_lock_ok_o}, 8'h15);
        @(posedge clock_i);
        hold_pin_i <= 0;
        acc(0, PHC_ADDR_HOLD_CTRL, 8'h00);
        chk({v[1:0], external_hold_o}, 8'h06);
        acc(1, PHC_ADDR_HOLD_CTRL, 8'h49);
        $display("hold control test done");
    endtask
    task automatic t_zd;
        for (int i = 0; i < 4; i++) begin
            acc(1, PHC_ADDR_ZD_CTRL, {3'h7, i[1:0], 3'h6});
            chk(outs, {5'h0a, i[1:0], 1'b1});
            acc(0, PHC_ADDR_ZD_CTRL, 8'h00);
            chk(v, {3'h0, i[1:0], 3'h6});
        end
        acc(1, PHC_ADDR_ZD_CTRL, 8'h02);
        chk({6'h0, zd_external_o, zd_internal_o}, 8'h01);
        $display("zero delay test done");
    endtask
    task automatic t_status;
        @(posedge clock_i);
        pll_status_i <= 6'h10;
        acc(0, PHC_ADDR_PLL_STATUS, 8'h00);
        chk(v, 8'h20);
        @(posedge clock_i);
        pll_status_i <= '1;
        acc(0, PHC_ADDR_PLL_STATUS, 8'h00);
        chk(v, 8'h7e);
        acc(1, PHC_ADDR_HOLD_CTRL, 8'h10);
        @(posedge clock_i);
        pll_status_i <= '0;
        acc(1, PHC_ADDR_PLL_STATUS, 8'h00);
        acc(0, PHC_ADDR_PLL_STATUS, 8'h00);
        chk(v, 8'h7e);
        acc(0, 10'h3ff, 8'h00);
        chk(v, 8'h00);
        acc(1, PHC_ADDR_HOLD_CTRL, 8'h00);
        acc(0, PHC_ADDR_PLL_STATUS, 8'h00);
        chk(v, 8'h00);
        $display("status freeze test done");
    endtask
    task automatic t_ce;
        @(posedge clock_i);
        ce_i <= 0;
        acc(1, PHC_ADDR_HOLD_CTRL, 8'h20);
        chk({7'h0, doubler_en_o}, 8'h00);
        @(posedge clock_i);
        ce_i <= 1;
        acc(0, PHC_ADDR_HOLD_CTRL, 8'h00);
        chk(v, 8'h00);
        $display("clock enable test done");
    endtask
    initial begin
        #20000;
        num_errors++;
        wrap_up;
    end
    initial begin
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1;
        t_hold;
        t_zd;
        t_status;
        t_ce;
        wrap_up;
    end
endmodule
